//--- lat_regs_map.vh
// Register map, field layouts, reset values and timing counts for the lane alarm and trim bank.
`ifndef LAT_REGS_MAP_VH
`define LAT_REGS_MAP_VH

// Printed offsets that are not multiples of four are register indices; byte address is 4x index.
`define LAT_IDX_CORE0_TRIM 12'h330
`define LAT_IDX_CORE1_TRIM 12'h332
`define LAT_IDX_CORE2A_TRIM 12'h334
`define LAT_IDX_CORE2B_TRIM 12'h336
`define LAT_IDX_CORE3C_TRIM 12'h338
// Registers placed here for lane flags, combined alarm, mask, calibration control and status.
`define LAT_IDX_LANE_FLAGS 12'h340
`define LAT_IDX_ALARM_STATUS 12'h341
`define LAT_IDX_ALARM_MASK 12'h342
`define LAT_IDX_CAL_CTRL 12'h343
`define LAT_IDX_CAL_STATUS 12'h344

// Field layouts.
`define LAT_TRIM_MSB 11
`define LAT_RSVD_MSB 15
`define LAT_RSVD_LSB 12
`define LAT_ALM_COMBINED_BIT 0
`define LAT_ALM_ACCESS_BIT 1
`define LAT_OFFSET_CAL_ENABLE_BIT 0
`define LAT_BACKGROUND_CAL_ENABLE_BIT 1
`define LAT_CONTINUOUS_OFFSET_CAL_ENABLE_BIT 2

// Reset values.
`define LAT_LANE_FLAGS_RST 8'hFF
`define LAT_ALARM_STATUS_RST 2'h3
`define LAT_ALARM_MASK_RST 2'h3
`define LAT_CAL_CTRL_RST 3'h0
`define LAT_TRIM_RSVD_RST 4'h0

// Fuse storage is loaded one cycle after reset release; count of cycles for the load.
`define LAT_FUSE_LOAD_CYCLES 1

`endif

//--- lat_regs.v
// Lane FIFO fault flags, offset-trim registers and alarm interrupt behind an APB slave.
`timescale 1ns/100ps
`include "lat_regs_map.vh"

// Function
// [RULE1] Eight sticky lane flags set on FIFO fault.
// [RULE2] Write one clears lane flag; persisting fault resets.
// [RULE3] Clearing combined alarm clears all lane flags.
// [RULE4] Any active lane fault sets combined alarm.
// [RULE5] All alarm bits read one after reset.
// [RULE6] Core 0 trim: 12-bit unsigned offset applied.
// [RULE7] Upper four trim bits reserved, kept, unused.
// [RULE8] Trim registers load defaults from fuse storage.
// [RULE9] Software avoids trims during offset calibration.
// [RULE10] Restricted case waits for foreground calibration done.
// [RULE11] Both background modes on: never touch trims.
// [RULE12] Recommended: offset on, background on, continuous off.
// [RULE13] Spare core offsets calibrated in foreground step.
// [RULE14] Other configurations allow trim access anytime.
// [RULE15] Core 1 trim: 12-bit offset applied.
// [RULE16] Core 2 has input A and B trims.
// [RULE17] Core 3 input C trim register.
// [RULE18] Zero writes keep flags; trim reads return applied.
module lat_regs #(
    parameter LANES = 8,
    parameter TRIM_W = 12
) (
    // Clock, reset and clock enable.
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // APB slave.
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [13:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire pready_out,
    output wire pslverr_out,
    output reg [31:0] prdata_out,
    // Lane FIFO fault pulses and active lane mask.
    input wire [LANES-1:0] lane_fault_in,
    input wire [LANES-1:0] lane_active_in,
    // Factory fuse defaults for the five trim registers.
    input wire [TRIM_W-1:0] fuse_core0_in,
    input wire [TRIM_W-1:0] fuse_core1_in,
    input wire [TRIM_W-1:0] fuse_core2a_in,
    input wire [TRIM_W-1:0] fuse_core2b_in,
    input wire [TRIM_W-1:0] fuse_core3c_in,
    // Calibration engine status.
    input wire offset_cal_busy_in,
    input wire foreground_cal_complete_in,
    input wire core2_on_input_b_in,
    // Calibration engine writes back trim values it found.
    input wire cal_trim_we_in,
    input wire [2:0] cal_trim_sel_in,
    input wire [TRIM_W-1:0] cal_trim_data_in,
    // Applied trims and calibration controls.
    output reg [TRIM_W-1:0] core0_offset_trim_out,
    output reg [TRIM_W-1:0] core1_offset_trim_out,
    output reg [TRIM_W-1:0] core2_offset_trim_out,
    output reg [TRIM_W-1:0] core3_input_c_offset_trim_out,
    output wire offset_cal_enable_out,
    output wire background_cal_enable_out,
    output wire continuous_offset_cal_enable_out,
    output wire spare_core_fg_offset_cal_out,
    // Interrupt.
    output wire irq_out
);

    localparam NTRIM = 5;

    // Trim storage: 12-bit value plus 4 kept reserved bits per register.
    reg [TRIM_W-1:0] trim [0:NTRIM-1];
    reg [3:0] trim_rsvd [0:NTRIM-1];
    reg [LANES-1:0] per_lane_fifo_fault_flags;
    reg [1:0] alarm_status;
    reg [1:0] alarm_mask;
    reg [2:0] cal_ctrl;
    reg fuse_pending;
    reg [NTRIM-1:0] fuse_mask;

    wire [11:0] idx;
    wire wr_acc;
    wire rd_en;
    wire trim_hit;
    wire [2:0] trim_sel;
    wire any_fault;
    wire access_violation;
    reg [31:0] next_prdata;
    integer i;

    // Word index is the byte address divided by four.
    assign idx = paddr_in[13:2];
    assign wr_acc = ce_in & psel_in & penable_in & pwrite_in;
    assign rd_en = ce_in & psel_in & penable_in & ~pwrite_in;
    // Zero wait states keep the bus simple; every access completes in its first access cycle.
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~known(idx);

    // Maps a register index to its trim slot.
    function [2:0] trim_slot;
        input [11:0] a;
        begin
            case (a)
                `LAT_IDX_CORE0_TRIM: trim_slot = 3'h0;
                `LAT_IDX_CORE1_TRIM: trim_slot = 3'h1;
                `LAT_IDX_CORE2A_TRIM: trim_slot = 3'h2;
                `LAT_IDX_CORE2B_TRIM: trim_slot = 3'h3;
                `LAT_IDX_CORE3C_TRIM: trim_slot = 3'h4;
                default: trim_slot = 3'h7;
            endcase
        end
    endfunction

    // True for any mapped index.
    function known;
        input [11:0] a;
        begin
            known = (trim_slot(a) != 3'h7) || (a >= `LAT_IDX_LANE_FLAGS &&
                a <= `LAT_IDX_CAL_STATUS);
        end
    endfunction

    assign trim_sel = trim_slot(idx);
    assign trim_hit = (trim_sel != 3'h7);
    assign any_fault = |(lane_fault_in & lane_active_in);
    assign offset_cal_enable_out = cal_ctrl[`LAT_OFFSET_CAL_ENABLE_BIT];
    assign background_cal_enable_out = cal_ctrl[`LAT_BACKGROUND_CAL_ENABLE_BIT];
    assign continuous_offset_cal_enable_out = cal_ctrl[`LAT_CONTINUOUS_OFFSET_CAL_ENABLE_BIT];
    // Spare cores are still offset-calibrated in the foreground step in the recommended mode.
    assign spare_core_fg_offset_cal_out = cal_ctrl[`LAT_OFFSET_CAL_ENABLE_BIT]; // [RULE13]

    // Software is told when it breaks the access windows; the write itself still lands.
    assign access_violation = psel_in & penable_in & ce_in & trim_hit & (offset_cal_busy_in | // [RULE9]
        (cal_ctrl[`LAT_BACKGROUND_CAL_ENABLE_BIT] & cal_ctrl[`LAT_CONTINUOUS_OFFSET_CAL_ENABLE_BIT]) | // [RULE11]
        (cal_ctrl[`LAT_OFFSET_CAL_ENABLE_BIT] & ~(cal_ctrl[`LAT_BACKGROUND_CAL_ENABLE_BIT] & cal_ctrl[`LAT_CONTINUOUS_OFFSET_CAL_ENABLE_BIT])
        & ~foreground_cal_complete_in)); // [RULE10] [RULE14]

    // Lane and combined alarms: a fault in the clear cycle wins over the clear.
    always @(posedge clk_in) begin
        if (rst_in) begin
            per_lane_fifo_fault_flags <= `LAT_LANE_FLAGS_RST; // [RULE5]
            alarm_status <= `LAT_ALARM_STATUS_RST; // [RULE5]
            alarm_mask <= `LAT_ALARM_MASK_RST;
            cal_ctrl <= `LAT_CAL_CTRL_RST;
        end else if (ce_in) begin
            if (wr_acc && idx == `LAT_IDX_LANE_FLAGS) begin
                per_lane_fifo_fault_flags <= (per_lane_fifo_fault_flags &
                    ~pwdata_in[LANES-1:0]) | lane_fault_in; // [RULE2] [RULE18]
            end else if (wr_acc && idx == `LAT_IDX_ALARM_STATUS &&
                    pwdata_in[`LAT_ALM_COMBINED_BIT]) begin
                per_lane_fifo_fault_flags <= lane_fault_in; // [RULE3]
            end else begin
                per_lane_fifo_fault_flags <= per_lane_fifo_fault_flags | lane_fault_in; // [RULE1]
            end
            if (wr_acc && idx == `LAT_IDX_ALARM_STATUS) begin
                alarm_status <= (alarm_status & ~pwdata_in[1:0]) |
                    {access_violation, any_fault}; // [RULE4]
            end else begin
                alarm_status <= alarm_status | {access_violation, any_fault}; // [RULE4]
            end
            if (wr_acc && idx == `LAT_IDX_ALARM_MASK) begin
                alarm_mask <= pwdata_in[1:0];
            end
            if (wr_acc && idx == `LAT_IDX_CAL_CTRL) begin
                cal_ctrl <= pwdata_in[2:0];
            end
        end
    end

    // Level interrupt while any unmasked status bit stands.
    assign irq_out = |(alarm_status & ~alarm_mask);

    // Trim registers: fuse load after reset, then software or the calibration engine.
    always @(posedge clk_in) begin
        if (rst_in) begin
            fuse_pending <= 1'b1;
            for (i = 0; i < NTRIM; i = i + 1) begin
                trim[i] <= {TRIM_W{1'b0}};
                trim_rsvd[i] <= `LAT_TRIM_RSVD_RST;
            end
        end else if (ce_in) begin
            if (fuse_pending) begin
                // Fuses are sampled after release so no port feeds the reset branch.
                fuse_pending <= 1'b0;
                trim[0] <= fuse_core0_in; // [RULE8]
                trim[1] <= fuse_core1_in; // [RULE8]
                trim[2] <= fuse_core2a_in; // [RULE8]
                trim[3] <= fuse_core2b_in; // [RULE8]
                trim[4] <= fuse_core3c_in; // [RULE8]
            end else if (wr_acc && trim_hit) begin
                trim[trim_sel] <= pwdata_in[`LAT_TRIM_MSB:0]; // [RULE6] [RULE15] [RULE17]
                trim_rsvd[trim_sel] <= pwdata_in[`LAT_RSVD_MSB:`LAT_RSVD_LSB]; // [RULE7]
            end else if (cal_trim_we_in && cal_trim_sel_in < NTRIM) begin
                trim[cal_trim_sel_in] <= cal_trim_data_in;
            end
        end
    end

    // Applied trims; core 2 follows the input it samples, and reserved bits touch nothing.
    always @(posedge clk_in) begin
        if (rst_in) begin
            core0_offset_trim_out <= {TRIM_W{1'b0}};
            core1_offset_trim_out <= {TRIM_W{1'b0}};
            core2_offset_trim_out <= {TRIM_W{1'b0}};
            core3_input_c_offset_trim_out <= {TRIM_W{1'b0}};
        end else if (ce_in) begin
            core0_offset_trim_out <= trim[0]; // [RULE6]
            core1_offset_trim_out <= trim[1]; // [RULE15]
            core2_offset_trim_out <= core2_on_input_b_in ? trim[3] : trim[2]; // [RULE16]
            core3_input_c_offset_trim_out <= trim[4]; // [RULE17]
        end
    end

    // Read mux.
    always @* begin
        next_prdata = 32'h0000_0000;
        if (trim_hit) begin
            next_prdata[15:0] = {trim_rsvd[trim_sel], trim[trim_sel]}; // [RULE18]
        end else begin
            case (idx)
                `LAT_IDX_LANE_FLAGS: next_prdata[LANES-1:0] = per_lane_fifo_fault_flags;
                `LAT_IDX_ALARM_STATUS: next_prdata[1:0] = alarm_status;
                `LAT_IDX_ALARM_MASK: next_prdata[1:0] = alarm_mask;
                `LAT_IDX_CAL_CTRL: next_prdata[2:0] = cal_ctrl;
                `LAT_IDX_CAL_STATUS: next_prdata[1:0] = {offset_cal_busy_in,
                    foreground_cal_complete_in};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Read data registered in the setup cycle so it is stable through the access cycle.
    always @(posedge clk_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (ce_in && psel_in && !penable_in) begin
            prdata_out <= next_prdata;
        end
    end

endmodule

//--- lat_regs_checker.sv
// Port-level assertions for the lane alarm and offset-trim register bank.
`timescale 1ns/100ps
`include "lat_regs_map.vh"
module lat_regs_checker #(
    parameter TRIM_W = 12
) (
    // Ports are grouped to keep the watcher compact.
    input wire clk_in, rst_in, ce_in, psel_in, penable_in, pwrite_in, core2_on_input_b_in,
    input wire [13:0] paddr_in,
    input wire [31:0] pwdata_in, prdata_out,
    input wire [TRIM_W-1:0] fuse_core0_in, core0_offset_trim_out, core1_offset_trim_out,
    input wire [TRIM_W-1:0] core2_offset_trim_out, core3_input_c_offset_trim_out,
    input wire offset_cal_enable_out, spare_core_fg_offset_cal_out, irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // A completed APB write to one word index at a running edge.
    sequence s_wr(idx);
        psel_in && penable_in && pwrite_in && ce_in && paddr_in[13:2] == idx;
    endsequence
    // A read setup of the core 0 trim followed by its access cycle.
    sequence s_rd_trim0;
        psel_in && !penable_in && !pwrite_in && ce_in
            && paddr_in[13:2] == `LAT_IDX_CORE0_TRIM ##1 penable_in;
    endsequence
    // Storage moves at the write edge and the output one edge later, hence two edges on.
    property p_trim(idx, ok, out);
        s_wr(idx) ##1 (ce_in && ok) |=> out == $past(pwdata_in[11:0], 2);
    endproperty
    AST_CORE0_TRIM:
    assert property (p_trim(`LAT_IDX_CORE0_TRIM, 1'h1, core0_offset_trim_out))
        else $error("core 0 trim output does not follow its write");
    AST_CORE1_TRIM:
    assert property (p_trim(`LAT_IDX_CORE1_TRIM, 1'h1, core1_offset_trim_out))
        else $error("core 1 trim output does not follow its write");
    AST_CORE2A_TRIM:
    assert property (p_trim(`LAT_IDX_CORE2A_TRIM, !core2_on_input_b_in, core2_offset_trim_out))
        else $error("core 2 input A trim not applied");
    AST_CORE2B_TRIM:
    assert property (p_trim(`LAT_IDX_CORE2B_TRIM, core2_on_input_b_in, core2_offset_trim_out))
        else $error("core 2 input B trim not applied");
    AST_CORE3C_TRIM:
    assert property (p_trim(`LAT_IDX_CORE3C_TRIM, 1'h1, core3_input_c_offset_trim_out))
        else $error("core 3 input C trim output does not follow its write");
    AST_FUSE_LOAD:
    assert property (($fell(rst_in) && ce_in) ##1 ce_in
        |=> core0_offset_trim_out == $past(fuse_core0_in, 2))
        else $error("core 0 trim did not take its fuse default");
    AST_IRQ_RESET:
    assert property ($fell(rst_in) |-> !irq_out)
        else $error("interrupt raised straight after reset");
    AST_CAL_SPARE:
    assert property (s_wr(`LAT_IDX_CAL_CTRL) |=> offset_cal_enable_out ==
        $past(pwdata_in[`LAT_OFFSET_CAL_ENABLE_BIT]) && spare_core_fg_offset_cal_out == offset_cal_enable_out)
        else $error("spare core calibration does not track offset enable");
    AST_TRIM_READ:
    assert property (s_rd_trim0 |-> prdata_out == {20'h0, core0_offset_trim_out})
        else $error("core 0 trim read differs from applied value");
endmodule

bind lat_regs lat_regs_checker #(.TRIM_W(TRIM_W)) u_chk (.*);

//--- tb_top.sv
// Self-checking bench for the lane alarm and offset-trim register bank.
`timescale 1ns/100ps
`include "lat_regs_map.vh"
module tb_top;
    logic clk_in = 0, rst_in = 1, ce_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [13:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, prdata_out, q;
    logic pready_out, pslverr_out, irq_out, last_err;
    logic [7:0] lane_fault_in = 0, lane_active_in = 0;
    logic [11:0] fuse_core0_in = 12'h1A5, fuse_core1_in = 12'h2B6, fuse_core2a_in = 12'h3C7;
    logic [11:0] fuse_core2b_in = 12'h4D8, fuse_core3c_in = 12'h5E9, cal_trim_data_in = 0;
    logic offset_cal_busy_in = 0, foreground_cal_complete_in = 0, core2_on_input_b_in = 0;
    logic cal_trim_we_in = 0;
    logic [2:0] cal_trim_sel_in = 0;
    logic [11:0] core0_offset_trim_out, core1_offset_trim_out, core2_offset_trim_out;
    logic [11:0] core3_input_c_offset_trim_out;
    logic offset_cal_enable_out, background_cal_enable_out, continuous_offset_cal_enable_out;
    logic spare_core_fg_offset_cal_out;
    int err_count = 0, n_tests = 0, cyc = 0;
    lat_regs u_lat_regs (.*);
    // Free-running 125 MHz clock.
    initial forever #4 clk_in = ~clk_in;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'h1;
        pwrite_in <= w;
        paddr_in <= {idx, 2'h0};
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'h1;
        @(posedge clk_in);
        while (pready_out !== 1'h1 && n < 20) begin
            n++;
            @(posedge clk_in);
        end
        q = prdata_out;
        last_err = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] idx, input string nm, input logic [31:0] exp);
        bus(1'h0, idx, 32'h0);
        chk(nm, q, exp);
    endtask
    task automatic t_reset;
        rd(`LAT_IDX_LANE_FLAGS, "lanes_rst", 32'hFF);
        rd(`LAT_IDX_ALARM_STATUS, "status_rst", 32'h3);
        rd(`LAT_IDX_CORE0_TRIM, "core0_fuse", 32'h1A5);
        rd(`LAT_IDX_CORE3C_TRIM, "core3c_fuse", 32'h5E9);
        chk("irq_masked", irq_out, 1'h0);
    endtask
    task automatic t_combined;
        bus(1'h1, `LAT_IDX_ALARM_STATUS, 32'h3);
        rd(`LAT_IDX_LANE_FLAGS, "lanes_cleared", 32'h0);
        rd(`LAT_IDX_ALARM_STATUS, "status_cleared", 32'h0);
        lane_active_in <= 8'h04;
        lane_fault_in <= 8'h44;
        @(posedge clk_in);
        lane_fault_in <= 8'h00;
        rd(`LAT_IDX_ALARM_STATUS, "combined_set", 32'h1);
        rd(`LAT_IDX_LANE_FLAGS, "lanes_set", 32'h44);
        bus(1'h1, `LAT_IDX_ALARM_MASK, 32'h2);
        @(negedge clk_in);
        chk("irq_unmasked", irq_out, 1'h1);
        bus(1'h1, `LAT_IDX_ALARM_STATUS, 32'h1);
        @(negedge clk_in);
        chk("irq_cleared", irq_out, 1'h0);
        rd(`LAT_IDX_LANE_FLAGS, "combined_clears_lanes", 32'h0);
    endtask
    // Lanes 3 and 5 are inactive, so only their own flags may move.
    task automatic t_lanes;
        lane_fault_in <= 8'h08;
        @(posedge clk_in);
        lane_fault_in <= 8'h00;
        rd(`LAT_IDX_LANE_FLAGS, "lane3_set", 32'h08);
        bus(1'h1, `LAT_IDX_LANE_FLAGS, 32'h0);
        rd(`LAT_IDX_LANE_FLAGS, "zero_keeps", 32'h08);
        lane_fault_in <= 8'h20;
        bus(1'h1, `LAT_IDX_LANE_FLAGS, 32'h28);
        lane_fault_in <= 8'h00;
        rd(`LAT_IDX_LANE_FLAGS, "fault_persists", 32'h20);
        bus(1'h1, `LAT_IDX_LANE_FLAGS, 32'h20);
        rd(`LAT_IDX_LANE_FLAGS, "w1c", 32'h0);
        rd(`LAT_IDX_ALARM_STATUS, "inactive_lanes", 32'h0);
    endtask
    task automatic t_trims;
        logic [11:0] ix [5];
        logic [11:0] v [5];
        ix = '{`LAT_IDX_CORE0_TRIM, `LAT_IDX_CORE1_TRIM, `LAT_IDX_CORE2A_TRIM,
            `LAT_IDX_CORE2B_TRIM, `LAT_IDX_CORE3C_TRIM};
        for (int i = 0; i < 5; i++) begin
            v[i] = 12'((i + 1) * 12'h123);
            bus(1'h1, ix[i], {20'h0, v[i]});
        end
        for (int i = 0; i < 5; i++) begin
            rd(ix[i], "trim_readback", {20'h0, v[i]});
        end
        @(negedge clk_in);
        chk("core0_out", core0_offset_trim_out, v[0]);
        chk("core1_out", core1_offset_trim_out, v[1]);
        chk("core2a_out", core2_offset_trim_out, v[2]);
        chk("core3c_out", core3_input_c_offset_trim_out, v[4]);
        @(posedge clk_in);
        core2_on_input_b_in <= 1'h1;
        bus(1'h1, `LAT_IDX_CORE2B_TRIM, 32'hABC);
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        chk("core2b_out", core2_offset_trim_out, 12'hABC);
        @(posedge clk_in);
        cal_trim_we_in <= 1'h1;
        cal_trim_sel_in <= 3'h1;
        cal_trim_data_in <= 12'h777;
        @(posedge clk_in);
        cal_trim_we_in <= 1'h0;
        rd(`LAT_IDX_CORE1_TRIM, "engine_writeback", 32'h777);
    endtask
    task automatic t_cal;
        // Recommended background setting: offset on, background on, continuous off.
        bus(1'h1, `LAT_IDX_CAL_CTRL, 32'h3);
        @(negedge clk_in);
        chk("cal_outs", {offset_cal_enable_out, background_cal_enable_out,
            continuous_offset_cal_enable_out, spare_core_fg_offset_cal_out}, 4'hD);
        rd(`LAT_IDX_CORE0_TRIM, "trim_during_cal", 32'h123);
        rd(`LAT_IDX_ALARM_STATUS, "early_access_flag", 32'h2);
        // Once foreground calibration is done, a trim access is legal and raises no flag.
        bus(1'h1, `LAT_IDX_ALARM_STATUS, 32'h2);
        foreground_cal_complete_in <= 1'h1;
        rd(`LAT_IDX_CORE0_TRIM, "trim_after_done", 32'h123);
        rd(`LAT_IDX_ALARM_STATUS, "done_access_ok", 32'h0);
        rd(`LAT_IDX_CAL_STATUS, "cal_status_done", 32'h1);
        // A trim access while the engine is busy is flagged.
        offset_cal_busy_in <= 1'h1;
        rd(`LAT_IDX_CORE0_TRIM, "trim_while_busy", 32'h123);
        offset_cal_busy_in <= 1'h0;
        rd(`LAT_IDX_ALARM_STATUS, "busy_access_flag", 32'h2);
        bus(1'h1, `LAT_IDX_ALARM_STATUS, 32'h2);
        // Both background modes on: any trim access is flagged.
        bus(1'h1, `LAT_IDX_CAL_CTRL, 32'h6);
        rd(`LAT_IDX_CORE0_TRIM, "trim_bg_bgos", 32'h123);
        rd(`LAT_IDX_ALARM_STATUS, "bg_bgos_flag", 32'h2);
        bus(1'h1, `LAT_IDX_ALARM_STATUS, 32'h2);
        // Calibration off: trims may be touched at any time.
        bus(1'h1, `LAT_IDX_CAL_CTRL, 32'h0);
        rd(`LAT_IDX_CORE0_TRIM, "trim_free", 32'h123);
        rd(`LAT_IDX_ALARM_STATUS, "free_access_ok", 32'h0);
        bus(1'h0, 12'h3FF, 32'h0);
        chk("unmapped_err", last_err, 1'h1);
        chk("unmapped_data", q, 32'h0);
    endtask
    // A hang counts as a mismatch and ends the run.
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            finish_test();
        end
    end
    // Reset for four cycles, then the scenarios in order.
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'h0;
        t_reset();
        t_combined();
        t_lanes();
        t_trims();
        t_cal();
        finish_test();
    end
endmodule
